// ===== acac_pkg.sv
// register map, field positions and limits of the calibration/average/correction block
// assumes a byte-wide register port and an analog core clocked by clk
package acac_pkg;
    // register addresses on the byte port
    localparam logic [5:0] A_CTL = 6'h00;
    localparam logic [5:0] A_STAT = 6'h01;
    localparam logic [5:0] A_CFG = 6'h02;
    localparam logic [5:0] A_RESH = 6'h03;
    localparam logic [5:0] A_RESL = 6'h04;
    localparam logic [5:0] A_OFSH = 6'h05;
    localparam logic [5:0] A_OFSL = 6'h06;
    localparam logic [5:0] A_PGH = 6'h07;
    localparam logic [5:0] A_PGL = 6'h08;
    localparam logic [5:0] A_MGH = 6'h09;
    localparam logic [5:0] A_MGL = 6'h0a;
    localparam logic [5:0] A_PINS = 6'h0b;
    localparam logic [1:0] A_CLP_PAGE = 2'h1; // 0x10 + 2k low, +1 high
    localparam logic [1:0] A_CLM_PAGE = 2'h2; // 0x20 + 2k low, +1 high
    // control, status and config bit positions
    localparam int CTL_CAL = 7;
    localparam int CTL_FAILED = 6;
    localparam int CTL_CONT = 3;
    localparam int CTL_AVG_ON = 2;
    localparam int CTL_AVG_CNT = 0;
    localparam int ST_ACT = 7;
    localparam int ST_COCO = 0;
    localparam int CFG_DIFF = 0;
    localparam int CFG_HWT = 1;
    // arithmetic
    localparam logic [15:0] GAIN_RST = 16'h8000; // 1.0 in 1.15 format
    localparam int GAIN_FRAC = 15;
    localparam int OFS_SHIFT = 4; // 16-bit left-justified to 12-bit result
    localparam logic signed [19:0] SE_MIN = 20'sh00000;
    localparam logic signed [19:0] SE_MAX = 20'sh00fff;
    localparam logic signed [19:0] DF_MIN = -20'sh01000;
    localparam logic signed [19:0] DF_MAX = 20'sh00fff;
    localparam logic [2:0] AVG_LOG_BASE = 3'h2; // code 00 means 2^2 samples
    // generated calibration values: seven per side, stored in 10-bit slots
    localparam int CAL_N = 7;
    localparam int CAL_W = 10;
    localparam int CAL_WIDTHS [CAL_N] = '{6, 7, 8, 9, 10, 6, 6};
    typedef enum logic [1:0] {S_IDLE, S_CONV, S_CAL} acac_state_e;
endpackage

// ===== acac_top.sv
// digital control of a successive-approximation converter: calibration,
// continuous conversion, hardware averaging, offset/gain correction, pin control
// assumes the analog core runs on clk and answers start with one done pulse
`timescale 1ns/1ps
module acac_top
    import acac_pkg::*;
#(
    parameter int RES_W = 12 // raw sample width from the analog core
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // system events on clk
    input wire logic hw_trigger,
    input wire logic stop_mode,
    // analog core
    output logic core_start,
    output logic core_abort,
    output logic core_diff,
    input wire logic core_done,
    input wire logic [RES_W-1:0] core_plus,
    input wire logic [RES_W-1:0] core_minus,
    output logic core_cal_start,
    input wire logic core_cal_done,
    input wire logic [15:0] core_cal_ofs,
    input wire logic [CAL_N*CAL_W-1:0] core_cal_plus,
    input wire logic [CAL_N*CAL_W-1:0] core_cal_minus,
    // conversion result
    output logic [15:0] conversion_result,
    output logic result_valid,
    output logic conversion_active,
    // pins of channels 0..7
    input wire logic [7:0] port_oe,
    input wire logic [7:0] port_pu,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pu,
    output logic [7:0] port_in
);
    localparam int ACC_W = RES_W + 5; // room for 32 samples

    // all block state in one record
    typedef struct packed {
        acac_state_e st;
        logic calibration_failed_flag;
        logic continuous_conversion_enable;
        logic hw_average_enable;
        logic [1:0] average_count_select;
        logic diff;
        logic hw_trigger_select;
        logic [15:0] ofs;
        logic [15:0] pgain;
        logic [15:0] mgain;
        logic [7:0] pin_dis;
        logic [CAL_N*CAL_W-1:0] plus_cal_values;
        logic [CAL_N*CAL_W-1:0] minus_cal_values;
        logic [ACC_W-1:0] acc_p;
        logic [ACC_W-1:0] acc_m;
        logic [5:0] samp;
        logic [15:0] res;
        logic coco;
        logic res_valid;
        logic start;
        logic abort;
        logic cal_start;
        logic [7:0] rdata;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] port_in;
    } acac_st_s;

    acac_st_s q_q;
    acac_st_s n_d;

    // low bits of a calibration slot that really exist
    function automatic logic [CAL_W-1:0] cal_mask(input logic [2:0] k);
        logic [CAL_W-1:0] m;
        m = '0;
        for (int i = 0; i < CAL_W; i++) begin
            m[i] = (int'(k) < CAL_N) && (i < CAL_WIDTHS[int'(k)]);
        end
        return m;
    endfunction

    // read value of a calibration register byte
    function automatic logic [7:0] cal_byte(input logic [CAL_N*CAL_W-1:0] v,
                                            input logic [2:0] k, input logic hi);
        logic [CAL_W-1:0] s;
        s = '0;
        if (int'(k) < CAL_N) begin
            s = v[int'(k)*CAL_W +: CAL_W] & cal_mask(k);
        end
        return hi ? {6'h00, s[9:8]} : s[7:0];
    endfunction

    // datapath signals
    logic [2:0] avg_log;
    logic [5:0] need;
    logic last;
    logic [ACC_W-1:0] sum_p;
    logic [ACC_W-1:0] sum_m;
    logic [RES_W-1:0] avg_p;
    logic [RES_W-1:0] avg_m;
    logic [RES_W+15:0] prod_p;
    logic [RES_W+15:0] prod_m;
    logic signed [19:0] corr;
    logic signed [19:0] ofs_s;
    logic signed [19:0] lim_lo;
    logic signed [19:0] lim_hi;
    logic [15:0] res_sat;
    logic [7:0] rd_val;
    logic wr_ctl;
    logic cal_go;
    logic sw_go;
    logic conv_go;
    logic cal_fail;

    // sample count per result: 1, or 4 << code when averaging
    always_comb begin
        avg_log = q_q.hw_average_enable ? AVG_LOG_BASE + {1'b0, q_q.average_count_select}
                                        : 3'h0;
        need = 6'h01 << avg_log;
        last = (q_q.samp == 6'(need - 6'h01));
    end

    // average both sides, apply gains and offset, then clamp
    always_comb begin
        sum_p = q_q.acc_p + ACC_W'(core_plus);
        sum_m = q_q.acc_m + ACC_W'(core_minus);
        avg_p = RES_W'(sum_p >> avg_log);
        avg_m = RES_W'(sum_m >> avg_log);
        prod_p = (RES_W+16)'(avg_p) * (RES_W+16)'(q_q.pgain);
        prod_m = (RES_W+16)'(avg_m) * (RES_W+16)'(q_q.mgain);
        ofs_s = $signed({{4{q_q.ofs[15]}}, q_q.ofs}) >>> OFS_SHIFT;
        corr = $signed(20'(prod_p >> GAIN_FRAC)) - ofs_s;
        if (q_q.diff) begin
            corr = corr - $signed(20'(prod_m >> GAIN_FRAC));
        end
        lim_lo = q_q.diff ? DF_MIN : SE_MIN;
        lim_hi = q_q.diff ? DF_MAX : SE_MAX;
        // clamp instead of wrapping
        if (corr > lim_hi) begin
            res_sat = 16'(lim_hi);
        end else if (corr < lim_lo) begin
            res_sat = 16'(lim_lo);
        end else begin
            res_sat = 16'(corr);
        end
    end

    // register read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_val = 8'h00;
        case (reg_addr)
            A_CTL: begin
                rd_val[CTL_CAL] = (q_q.st == S_CAL);
                rd_val[CTL_FAILED] = q_q.calibration_failed_flag;
                rd_val[CTL_CONT] = q_q.continuous_conversion_enable;
                rd_val[CTL_AVG_ON] = q_q.hw_average_enable;
                rd_val[CTL_AVG_CNT +: 2] = q_q.average_count_select;
            end
            A_STAT: begin
                rd_val[ST_ACT] = (q_q.st == S_CONV);
                rd_val[ST_COCO] = q_q.coco;
            end
            A_CFG: begin
                rd_val[CFG_DIFF] = q_q.diff;
                rd_val[CFG_HWT] = q_q.hw_trigger_select;
            end
            A_RESH: rd_val = q_q.res[15:8];
            A_RESL: rd_val = q_q.res[7:0];
            A_OFSH: rd_val = q_q.ofs[15:8];
            A_OFSL: rd_val = q_q.ofs[7:0];
            A_PGH: rd_val = q_q.pgain[15:8];
            A_PGL: rd_val = q_q.pgain[7:0];
            A_MGH: rd_val = q_q.mgain[15:8];
            A_MGL: rd_val = q_q.mgain[7:0];
            A_PINS: rd_val = q_q.pin_dis;
            default: begin
                if (reg_addr[5:4] == A_CLP_PAGE) begin
                    rd_val = cal_byte(q_q.plus_cal_values, reg_addr[3:1], reg_addr[0]);
                end else if (reg_addr[5:4] == A_CLM_PAGE) begin
                    rd_val = cal_byte(q_q.minus_cal_values, reg_addr[3:1], reg_addr[0]);
                end
            end
        endcase
    end

    // next state of the whole block
    always_comb begin
        n_d = q_q;
        n_d.start = 1'b0;
        n_d.abort = 1'b0;
        n_d.cal_start = 1'b0;
        n_d.res_valid = 1'b0;
        n_d.rdata = 8'h00;
        // pad inputs are asynchronous: two flops before use
        n_d.sync1 = pad_in;
        n_d.sync2 = q_q.sync1;
        n_d.port_in = q_q.sync2 & ~q_q.pin_dis;
        wr_ctl = reg_wr && (reg_addr == A_CTL);
        cal_go = wr_ctl && reg_wdata[CTL_CAL] && (q_q.st != S_CAL);
        // a config write is the software initiation, ignored when it selects trigger mode
        sw_go = reg_wr && (reg_addr == A_CFG) && !reg_wdata[CFG_HWT];
        conv_go = sw_go || (hw_trigger && q_q.hw_trigger_select);
        cal_fail = 1'b0;
        // read data appear in the following cycle only
        if (reg_rd) begin
            n_d.rdata = rd_val;
        end
        // reading the low result byte retires the completion flag
        if (reg_rd && (reg_addr == A_RESL)) begin
            n_d.coco = 1'b0;
        end
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                A_CTL: begin
                    n_d.continuous_conversion_enable = reg_wdata[CTL_CONT];
                    n_d.hw_average_enable = reg_wdata[CTL_AVG_ON];
                    n_d.average_count_select = reg_wdata[CTL_AVG_CNT +: 2];
                    if (reg_wdata[CTL_FAILED]) begin
                        n_d.calibration_failed_flag = 1'b0;
                    end
                end
                A_CFG: begin
                    n_d.diff = reg_wdata[CFG_DIFF];
                    n_d.hw_trigger_select = reg_wdata[CFG_HWT];
                end
                A_OFSH: n_d.ofs[15:8] = reg_wdata;
                A_OFSL: n_d.ofs[7:0] = reg_wdata;
                A_PGH: n_d.pgain[15:8] = reg_wdata;
                A_PGL: n_d.pgain[7:0] = reg_wdata;
                A_MGH: n_d.mgain[15:8] = reg_wdata;
                A_MGL: n_d.mgain[7:0] = reg_wdata;
                A_PINS: n_d.pin_dis = reg_wdata;
                default: begin
                    // generated values stay writable; unused bits are dropped
                    if (reg_addr[5:4] == A_CLP_PAGE && int'(reg_addr[3:1]) < CAL_N) begin
                        if (reg_addr[0]) begin
                            n_d.plus_cal_values[int'(reg_addr[3:1])*CAL_W+8 +: 2] =
                                reg_wdata[1:0];
                        end else begin
                            n_d.plus_cal_values[int'(reg_addr[3:1])*CAL_W +: 8] = reg_wdata;
                        end
                    end else if (reg_addr[5:4] == A_CLM_PAGE && int'(reg_addr[3:1]) < CAL_N) begin
                        if (reg_addr[0]) begin
                            n_d.minus_cal_values[int'(reg_addr[3:1])*CAL_W+8 +: 2] =
                                reg_wdata[1:0];
                        end else begin
                            n_d.minus_cal_values[int'(reg_addr[3:1])*CAL_W +: 8] = reg_wdata;
                        end
                    end
                end
            endcase
        end
        // conversion and calibration sequencer
        case (q_q.st)
            S_IDLE: begin
                if (conv_go) begin
                    n_d.st = S_CONV;
                    n_d.start = 1'b1;
                    n_d.acc_p = '0;
                    n_d.acc_m = '0;
                    n_d.samp = 6'h00;
                end
            end
            S_CONV: begin
                // trigger edges are ignored while busy; a software write restarts
                if (sw_go) begin
                    n_d.abort = 1'b1;
                    n_d.start = 1'b1;
                    n_d.acc_p = '0;
                    n_d.acc_m = '0;
                    n_d.samp = 6'h00;
                end else if (core_done) begin
                    if (last) begin
                        n_d.res = res_sat;
                        n_d.res_valid = 1'b1;
                        n_d.coco = 1'b1;
                        n_d.acc_p = '0;
                        n_d.acc_m = '0;
                        n_d.samp = 6'h00;
                        if (q_q.continuous_conversion_enable) begin
                            n_d.start = 1'b1;
                        end else begin
                            n_d.st = S_IDLE;
                        end
                    end else begin
                        // more samples of the averaged set to go
                        n_d.acc_p = sum_p;
                        n_d.acc_m = sum_m;
                        n_d.samp = 6'(q_q.samp + 6'h01);
                        n_d.start = 1'b1;
                    end
                end
            end
            S_CAL: begin
                // any write or trigger mode spoils the sequence
                cal_fail = q_q.hw_trigger_select || reg_wr || stop_mode;
                if (stop_mode) begin
                    n_d.abort = 1'b1;
                    n_d.st = S_IDLE;
                end else if (core_cal_done) begin
                    n_d.ofs = core_cal_ofs;
                    n_d.plus_cal_values = core_cal_plus;
                    n_d.minus_cal_values = core_cal_minus;
                    n_d.st = S_IDLE;
                end
            end
            default: n_d.st = S_IDLE;
        endcase
        // calibration start overrides any conversion
        if (cal_go) begin
            n_d.abort = (q_q.st == S_CONV);
            n_d.start = 1'b0;
            n_d.st = S_CAL;
            n_d.cal_start = 1'b1;
            cal_fail = q_q.hw_trigger_select;
        end
        // hardware set wins over a clear in the same cycle
        if (cal_fail) begin
            n_d.calibration_failed_flag = 1'b1;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_q <= '0;
            q_q.st <= S_IDLE;
            q_q.pgain <= GAIN_RST;
            q_q.mgain <= GAIN_RST;
        end else begin
            q_q <= n_d;
        end
    end

    // outputs; pad enables are a pure gate so a set bit acts at once
    assign reg_rdata = q_q.rdata;
    assign core_start = q_q.start;
    assign core_abort = q_q.abort;
    assign core_diff = q_q.diff;
    assign core_cal_start = q_q.cal_start;
    assign conversion_result = q_q.res;
    assign result_valid = q_q.res_valid;
    assign conversion_active = (q_q.st == S_CONV);
    assign pad_oe = port_oe & ~q_q.pin_dis;
    assign pad_pu = port_pu & ~q_q.pin_dis;
    assign port_in = q_q.port_in;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cal_start;
        cal_go |=> (q_q.st == S_CAL) && core_cal_start;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("cal start lost");

    property p_cal_abort;
        (cal_go && conversion_active) |=> core_abort && !conversion_active && !core_start;
    endproperty
    a_cal_abort: assert property (p_cal_abort) else $error("conversion not aborted");

    property p_fail_set;
        (q_q.st == S_CAL && (reg_wr || q_q.hw_trigger_select)) |=> q_q.calibration_failed_flag;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("failed flag not set");

    property p_fail_clear;
        $fell(q_q.calibration_failed_flag) |->
            $past(wr_ctl) && $past(reg_wdata[CTL_FAILED]);
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("flag cleared wrongly");

    property p_single;
        (q_q.st == S_CONV && core_done && last && !sw_go && !cal_go
         && !q_q.continuous_conversion_enable) |=> !conversion_active ##1 !core_start;
    endproperty
    a_single: assert property (p_single) else $error("single mode repeated");

    property p_avg_hold;
        (q_q.st == S_CONV && core_done && !last && !sw_go && !cal_go) |=>
            !result_valid && core_start;
    endproperty
    a_avg_hold: assert property (p_avg_hold) else $error("result before set end");

    property p_sat;
        result_valid && !q_q.diff |-> conversion_result <= 16'(SE_MAX);
    endproperty
    a_sat: assert property (p_sat) else $error("result above limit");

    property p_cal_load;
        (q_q.st == S_CAL && core_cal_done && !stop_mode && !cal_go) |=>
            q_q.ofs == $past(core_cal_ofs) && q_q.plus_cal_values == $past(core_cal_plus);
    endproperty
    a_cal_load: assert property (p_cal_load) else $error("cal values not loaded");

    property p_pins;
        (pad_oe & q_q.pin_dis) == 8'h00 && (pad_pu & q_q.pin_dis) == 8'h00;
    endproperty
    a_pins: assert property (p_pins) else $error("disabled pin still driven");

    c_avg32: cover property (q_q.st == S_CONV && q_q.average_count_select == 2'h3
                              && q_q.hw_average_enable ##1 result_valid);
    c_cal_ok: cover property (q_q.st == S_CAL ##[1:50] q_q.st == S_IDLE);
    c_cont: cover property (result_valid ##[1:300] result_valid);
endmodule

// ===== acac_core_model.sv
// behavioural analog converter core facing the control block
// assumes one-cycle request pulses on clk; samples and speed come from the bench
`timescale 1ns/1ps
module acac_core_model #(
    parameter logic [15:0] CAL_OFS = 16'h0130 // arbitrary calibration offset
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests
    input wire logic core_start,
    input wire logic core_abort,
    input wire logic core_cal_start,
    // bench choices
    input wire logic [11:0] smp_p,
    input wire logic [11:0] smp_m,
    input wire logic slow,
    // answers
    output logic core_done,
    output logic [11:0] core_plus,
    output logic [11:0] core_minus,
    output logic core_cal_done,
    output logic [15:0] core_cal_ofs,
    output logic [69:0] core_cal_plus,
    output logic [69:0] core_cal_minus
);
    logic [4:0] cnt_q; // cycles left in the job
    logic conv_q; // conversion running
    logic cal_q; // calibration running
    // data stand only beside their strobe; the inverse otherwise catches a late capture
    assign core_plus = core_done ? smp_p : ~smp_p;
    assign core_minus = core_done ? smp_m : ~smp_m;
    assign core_cal_ofs = core_cal_done ? CAL_OFS : ~CAL_OFS;
    assign core_cal_plus = {7{core_cal_done ? 10'h155 : 10'h2aa}};
    assign core_cal_minus = {7{core_cal_done ? 10'h2aa : 10'h155}};
    // one job at a time; a new request wins over an abort in the same cycle
    always @(posedge clk) begin
        core_done <= 1'b0;
        core_cal_done <= 1'b0;
        if (!rst_n) begin
            conv_q <= 1'b0;
            cal_q <= 1'b0;
            cnt_q <= 5'h00;
        end else if (core_cal_start) begin
            cal_q <= 1'b1;
            conv_q <= 1'b0;
            cnt_q <= 5'h14;
        end else if (core_start) begin
            conv_q <= 1'b1;
            cnt_q <= slow ? 5'h09 : 5'h01;
        end else if (core_abort) begin
            conv_q <= 1'b0;
            cal_q <= 1'b0;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else if (conv_q) begin
            core_done <= 1'b1;
            conv_q <= 1'b0;
        end else if (cal_q) begin
            core_cal_done <= 1'b1;
            cal_q <= 1'b0;
        end
    end
endmodule

// ===== test_acac_top.sv
// self-checking bench of the calibration/average/correction block
// assumes the behavioural core model on the analog side
`timescale 1ns/1ps
module test_acac_top;
    import acac_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, hw_trigger, stop_mode, slow;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, port_oe, port_pu, pad_in, pad_oe, pad_pu, port_in, pm, v;
    logic core_start, core_abort, core_diff, core_done, core_cal_start, core_cal_done;
    logic result_valid, conversion_active;
    logic [11:0] smp_p, smp_m, core_plus, core_minus;
    logic [15:0] core_cal_ofs, conversion_result, res_q, ofs, pg, mg;
    logic [CAL_N*CAL_W-1:0] core_cal_plus, core_cal_minus;
    logic [31:0] seed = 32'd24;
    int fail_count = 0, n_compared = 0, ndone, nres, navg;
    acac_top acac_top_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .hw_trigger, .stop_mode, .core_start, .core_abort, .core_diff, .core_done, .core_plus,
        .core_minus, .core_cal_start, .core_cal_done, .core_cal_ofs, .core_cal_plus,
        .core_cal_minus, .conversion_result, .result_valid, .conversion_active, .port_oe,
        .port_pu, .pad_in, .pad_oe, .pad_pu, .port_in);
    acac_core_model acac_core_model_inst (.clk, .rst_n, .core_start, .core_abort,
        .core_cal_start, .smp_p, .smp_m, .slow, .core_done, .core_plus, .core_minus,
        .core_cal_done, .core_cal_ofs, .core_cal_plus, .core_cal_minus);
    // clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count samples and catch each result
    always @(posedge clk) begin
        if (core_done === 1'b1) ndone++;
        if (result_valid === 1'b1) begin
            res_q <= conversion_result;
            nres++;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // corrected and clamped result for constant samples
    function automatic logic [15:0] exp_res(input logic d);
        int r;
        r = ((int'(smp_p) * int'(pg)) >>> 15) - (d ? (int'(smp_m) * int'(mg)) >>> 15 : 0);
        r = r - (int'($signed(ofs)) >>> 4);
        if (r < (d ? -4096 : 0)) r = d ? -4096 : 0;
        if (r > 4095) r = 4095;
        return r[15:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register cycles: signals change just after an edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // one read; the data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    endtask
    task automatic chkr(input logic [5:0] a, input logic [7:0] e);
        rd(a);
        chk(v, e);
    endtask
    task automatic setup(input logic [11:0] p, m, input logic [15:0] o, g1, g2,
                         input logic [7:0] c);
        smp_p <= p;
        smp_m <= m;
        ofs = o;
        pg = g1;
        mg = g2;
        navg = c[2] ? 4 << c[1:0] : 1;
        wr(A_OFSH, o[15:8]);
        wr(A_OFSL, o[7:0]);
        wr(A_PGH, g1[15:8]);
        wr(A_PGL, g1[7:0]);
        wr(A_MGH, g2[15:8]);
        wr(A_MGL, g2[7:0]);
        wr(A_CTL, c);
    endtask
    // one initiation by software write or hardware trigger, then one checked result
    task automatic conv(input logic [7:0] cfg, input logic hw);
        logic [15:0] e;
        e = exp_res(cfg[0]);
        slow <= rnd() > 32'h80000000;
        wr(A_CFG, cfg);
        ndone = 0;
        nres = 0;
        if (hw) begin
            hw_trigger <= 1'b1;
            @(posedge clk);
            hw_trigger <= 1'b0;
            @(posedge clk);
        end
        @(negedge clk);
        chk(conversion_active, 1'b1);
        for (int i = 0; i < 3000 && nres == 0; i++) @(posedge clk);
        @(negedge clk);
        chk(res_q, e);
        chk(16'(ndone), 16'(navg));
        chk(conversion_active, 1'b0);
        chk(16'(core_diff), 16'(cfg[0]));
        @(posedge clk);
        chkr(A_STAT, 8'h01);
        chkr(A_RESH, e[15:8]);
        chkr(A_RESL, e[7:0]);
        chkr(A_STAT, 8'h00);
    endtask
    task automatic wait_cal();
        v = 8'h80;
        for (int i = 0; i < 200 && v[7] !== 1'b0; i++) rd(A_CTL);
    endtask
    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, hw_trigger, stop_mode, slow} = '0;
        {reg_addr, reg_wdata, port_oe, port_pu, pad_in} = '0;
        {smp_p, smp_m} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(6'h3f, 8'hff);
        chkr(6'h3f, 8'h00);
        chkr(A_PGH, 8'h80);
        chkr(A_MGH, 8'h80);
        chkr(A_CTL, 8'h00);
        // pin control against random port requests
        repeat (3) begin
            pm = 8'(rnd());
            port_oe <= 8'(rnd());
            port_pu <= 8'(rnd());
            pad_in <= 8'(rnd());
            wr(A_PINS, pm);
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk(pad_oe, port_oe & ~pm);
            chk(pad_pu, port_pu & ~pm);
            chk(port_in, pad_in & ~pm);
            @(posedge clk);
            chkr(A_PINS, pm);
        end
        // saturation corners and gains in both modes
        setup(12'h100, 12'h000, 16'h7ff0, 16'h8000, 16'h8000, 8'h00);
        conv(8'h00, 1'b0);
        setup(12'h000, 12'hfff, 16'h7ff0, 16'h8000, 16'h8000, 8'h00);
        conv(8'h01, 1'b0);
        setup(12'hff0, 12'h000, 16'h8000, 16'h8000, 16'h8000, 8'h00);
        conv(8'h01, 1'b0);
        setup(12'h801, 12'h7ff, 16'h0000, 16'h4000, 16'h4000, 8'h00);
        conv(8'h00, 1'b0);
        conv(8'h01, 1'b0);
        for (int c = 0; c < 4; c++) begin
            setup(12'(rnd()), 12'(rnd()), 16'(rnd()), 16'h8000, 16'h8000, 8'(4 + c));
            conv(8'h00, 1'b0);
        end
        repeat (8) begin
            setup(12'(rnd()), 12'(rnd()), 16'(rnd()), 16'(rnd()), 16'(rnd()), 8'(rnd() & 7));
            conv(8'(rnd() & 1), 1'b0);
        end
        // continuous sets, then calibration aborts them
        setup(12'h321, 12'h000, 16'h0100, 16'h8000, 16'h8000, 8'h0c);
        nres = 0;
        wr(A_CFG, 8'h00);
        for (int i = 0; i < 3000 && nres < 3; i++) @(posedge clk);
        @(negedge clk);
        chk(16'(nres), 16'd3);
        chk(res_q, exp_res(1'b0));
        @(posedge clk);
        wr(A_CTL, 8'h80);
        @(negedge clk);
        chk(conversion_active, 1'b0);
        @(posedge clk);
        chkr(A_CTL, 8'h80);
        wait_cal();
        chkr(A_CTL, 8'h00);
        chkr(A_OFSH, 8'h01);
        chkr(A_OFSL, 8'h30);
        chkr(6'h18, 8'h55);
        chkr(6'h19, 8'h01);
        chkr(6'h28, 8'haa);
        chkr(6'h29, 8'h02);
        // failed calibrations: register write, stop mode, hardware trigger select
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wr(A_CFG, 8'h02);
            wr(A_CTL, 8'h80);
            if (k == 0) wr(A_PINS, 8'h00);
            if (k == 1) begin
                stop_mode <= 1'b1;
                @(posedge clk);
                stop_mode <= 1'b0;
            end
            wait_cal();
            chkr(A_CTL, 8'h40);
            wr(A_CTL, 8'h00);
            chkr(A_CTL, 8'h40);
            wr(A_CTL, 8'h40);
            chkr(A_CTL, 8'h00);
        end
        setup(12'h456, 12'h000, 16'h0000, 16'h8000, 16'h8000, 8'h00);
        conv(8'h02, 1'b1);
        finish_test();
    end
endmodule
